// ---- verification/bbs_bbu_model.sv ----
// behavioural battery unit driving the discrete lines
`timescale 1ns/100ps
`default_nettype none
module bbs_bbu_model (
   input  wire logic                clk_in,         // clock
   input  wire logic                rst_in,         // reset
   input  wire logic                want_charge_in, // unit wants charge
   input  wire logic                want_test_in,   // unit wants a test
   input  wire logic                granted_in,     // test granted
   output var  bbs_pkg::bbs_lines_t lines_out      // eight lines
);
   logic worn_reg;
   // a granted test discharge judges the cells worn out
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         worn_reg <= 1'b0;
      end else if (granted_in) begin
         worn_reg <= 1'b1;
      end
   end
   // all eight lines driven, unused flags low
   always_comb begin
      lines_out                     = '0;
      lines_out.present             = 1'b1;
      lines_out.charge_request      = want_charge_in;
      lines_out.health_test_request = want_test_in;
      lines_out.battery_worn_out    = worn_reg;
   end
endmodule : bbs_bbu_model
`default_nettype wire

// ---- verification/bbs_chk.sv ----
// port-level assertions for the battery backup supervisor
`timescale 1ns/100ps
`default_nettype none
module bbs_chk #(
   parameter int unsigned TICK_CYCLES = 2,
   parameter int unsigned WARN_TICKS  = 20,
   parameter int unsigned LOAD_TICKS  = 10,
   parameter int unsigned OC_TICKS    = 5
) (
   input wire logic                clk_in,                   // clock
   input wire logic                rst_in,                   // reset
   input wire logic                ce_in,                    // enable
   input wire logic                ac_ok_in,                 // ac level
   input wire logic                freq_ok_in,               // frequency
   input wire logic                main_ov_in,               // fast ov
   input wire logic                main_oc_in,               // slow oc
   input wire logic                load_high_in,             // load
   input wire bbs_pkg::bbs_lines_t lines_in,                 // unit lines
   input wire bbs_pkg::bbs_shelf_t shelf_in,                 // shelf
   input wire logic                on_battery_out,           // dc mode
   input wire logic                soft_start_out,           // soft start
   input wire logic                main_enable_out,          // output on
   input wire logic                backup_power_warning_out, // warning
   input wire logic                charger_on_out,           // charger
   input wire logic                test_grant_out            // grant
);
   int unsigned dc_cnt;
   int unsigned load_cnt;
   int unsigned oc_cnt;
   // run lengths of battery time, heavy load and overcurrent
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         dc_cnt   <= '0;
         load_cnt <= '0;
         oc_cnt   <= '0;
      end else if (ce_in) begin
         dc_cnt   <= (on_battery_out && !(ac_ok_in && freq_ok_in)) ? dc_cnt + 1 : '0;
         load_cnt <= load_high_in ? load_cnt + 1 : '0;
         oc_cnt   <= main_oc_in ? oc_cnt + 1 : '0;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_battery_on_loss: assert property (
      ce_in && !(ac_ok_in && freq_ok_in) && main_enable_out && !on_battery_out
      |-> ##[1:2] on_battery_out)
      else $error("no switch to battery");
   a_soft_first: assert property ($rose(on_battery_out) |-> soft_start_out)
      else $error("battery entry without soft start");
   a_warn_late: assert property (
      $rose(backup_power_warning_out) |-> dc_cnt + TICK_CYCLES + 3 >= WARN_TICKS * TICK_CYCLES)
      else $error("warning too early");
   a_off_holds: assert property (
      !main_enable_out && !(ac_ok_in && freq_ok_in) |=> !main_enable_out)
      else $error("restart without valid ac");
   a_charge_cause: assert property (
      $rose(charger_on_out) |-> $past(lines_in.charge_request) && !$past(on_battery_out))
      else $error("charger started without request");
   a_grant_shelf: assert property (test_grant_out |-> lines_in.health_test_request
      && &shelf_in.installed && &shelf_in.comm_ok && !(|shelf_in.failed) && !(|shelf_in.testing)
      && !(|shelf_in.charging) && &shelf_in.on_ac && !on_battery_out && !charger_on_out)
      else $error("grant against shelf state");
   a_grant_load: assert property (
      test_grant_out |-> load_cnt + TICK_CYCLES + 2 >= LOAD_TICKS * TICK_CYCLES)
      else $error("grant before load qualified");
   a_ov_latch: assert property (ce_in && main_ov_in |-> ##[1:3] !main_enable_out)
      else $error("overvoltage did not latch off");
   a_oc_latch: assert property (
      oc_cnt == OC_TICKS * TICK_CYCLES + 1 |-> ##[0:1] !main_enable_out)
      else $error("overcurrent did not latch off");
endmodule : bbs_chk
bind bbs_supervisor bbs_chk #(.TICK_CYCLES(TICK_CYCLES), .WARN_TICKS(WARN_TICKS),
   .LOAD_TICKS(LOAD_TICKS), .OC_TICKS(OC_TICKS)) i_bbs_chk (.clk_in, .rst_in, .ce_in,
   .ac_ok_in, .freq_ok_in, .main_ov_in, .main_oc_in, .load_high_in, .lines_in, .shelf_in,
   .on_battery_out, .soft_start_out, .main_enable_out, .backup_power_warning_out,
   .charger_on_out, .test_grant_out);
`default_nettype wire

// ---- verification/bbs_tb.sv ----
// self-checking testbench for the battery backup supervisor
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk_in, rst_in, ce_in, ac_ok_in, freq_ok_in, main_ov_in, main_oc_in, batt_ov_in;
   logic batt_uv_in, load_high_in, wr_in, rd_in, i2c_done_in, want_charge, want_test, flag;
   logic i2c_start_out, on_battery_out, soft_start_out, main_enable_out, charger_on_out;
   logic backup_power_warning_out, test_grant_out;
   logic [3:0]          addr_in;
   logic [4:0]          charge_ramp_out;
   logic [7:0]          i2c_rdata_in;
   logic [15:0]         wdata_in, rdata_out, i2c_cmd_out, st;
   bbs_pkg::bbs_lines_t lines;
   bbs_pkg::bbs_shelf_t shelf_in, good, s;
   int                  miscompares, check_count, n, i;
   int                  d[2];
   bbs_supervisor #(.TICK_CYCLES(2), .WARN_TICKS(20), .SHUTDOWN_TICKS(1200), .CHARGE_TICKS(50),
      .LOAD_TICKS(10), .OC_TICKS(5)) i_bbs_supervisor (.clk_in, .rst_in, .ce_in, .ac_ok_in,
      .freq_ok_in, .main_ov_in, .main_oc_in, .batt_ov_in, .batt_uv_in, .load_high_in,
      .lines_in(lines), .shelf_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .i2c_done_in, .i2c_rdata_in, .i2c_start_out, .i2c_cmd_out, .on_battery_out,
      .soft_start_out, .main_enable_out, .backup_power_warning_out, .charger_on_out,
      .charge_ramp_out, .test_grant_out);
   bbs_bbu_model i_bbs_bbu_model (.clk_in, .rst_in, .want_charge_in(want_charge),
      .want_test_in(want_test), .granted_in(test_grant_out), .lines_out(lines));
   // verdict and end of run
   task results;
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results
   // comparisons and bounded waits
   task chk16(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk16
   task chk1(input logic got, input logic exp);
      chk16({15'h0000, got}, {15'h0000, exp});
   endtask : chk1
   task tmo(input int got, input int lim);
      if (got >= lim) begin
         miscompares++;
         results;
      end
   endtask : tmo
   task cyc(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask : cyc
   // register port cycles
   task wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= v;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      #1;
   endtask : wr
   task rd(input logic [3:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 st = rdata_out;
   endtask : rd
   // status after reset, unmapped read, link command and read-back
   task t_regs;
      rd(bbs_pkg::A_STATUS);
      chk16(st, 16'h0000);
      rd(4'h7);
      chk16(st, 16'h0000);
      wr(bbs_pkg::A_I2C_CMD, 16'hA55A);
      chk1(i2c_start_out, 1'b1);
      chk16(i2c_cmd_out, 16'hA55A);
      i2c_rdata_in <= 8'h3C;
      i2c_done_in  <= 1'b1;
      cyc(1);
      i2c_done_in <= 1'b0;
      chk1(i2c_start_out, 1'b0);
      rd(bbs_pkg::A_I2C_DATA);
      chk16(st, 16'h003C);
   endtask : t_regs
   // clock enable low freezes sequencer and status flags
   task t_hold;
      ce_in      <= 1'b0;
      freq_ok_in <= 1'b0;
      cyc(8);
      chk1(on_battery_out, 1'b0);
      ce_in      <= 1'b1;
      freq_ok_in <= 1'b1;
      rd(bbs_pkg::A_STATUS);
      chk16(st, 16'h0000);
   endtask : t_hold
   // each fault alone: latch timing of the two main faults, battery faults not latching, and its own status bit
   task t_faults;
      logic [15:0] exp [4];
      exp = '{16'h0202, 16'h0204, 16'h0008, 16'h0010};
      for (i = 0; i < 4; i++) begin
         {batt_uv_in, batt_ov_in, main_oc_in, main_ov_in} <= 4'h1 << i;
         for (n = 0; n < 20 && main_enable_out; n++) cyc(1);
         chk1(main_enable_out, i > 1);
         if (i == 0) chk1(n <= 3, 1'b1);
         if (i == 1) chk1(n >= 8, 1'b1);
         {batt_uv_in, batt_ov_in, main_oc_in, main_ov_in} <= 4'h0;
         rd(bbs_pkg::A_STATUS);
         chk16(st, exp[i]);
         wr(bbs_pkg::A_CLEAR, 16'h001E);
         cyc(3);
         chk1(main_enable_out, 1'b1);
      end
   endtask : t_faults
   // full backup: warning, shutdown, stay off, restart on ac
   task t_backup;
      ac_ok_in <= 1'b0;
      cyc(2);
      chk1(on_battery_out, 1'b1);
      chk1(soft_start_out, 1'b1);
      rd(bbs_pkg::A_STATUS);
      chk1(st[bbs_pkg::ST_AC_UV], 1'b1);
      for (n = 0; n < 100 && !backup_power_warning_out; n++) cyc(1);
      chk1(n >= 30 && on_battery_out, 1'b1);
      for (n = 0; n < 2600 && main_enable_out; n++) cyc(1);
      tmo(n, 2600);
      chk1(n >= 2300, 1'b1);
      cyc(20);
      chk1(main_enable_out, 1'b0);
      ac_ok_in <= 1'b1;
      for (n = 0; n < 30 && !main_enable_out; n++) cyc(1);
      chk1(main_enable_out && !on_battery_out, 1'b1);
   endtask : t_backup
   // short outages by frequency: clean return, varying delay
   task t_return;
      for (i = 0; i < 2; i++) begin
         freq_ok_in <= 1'b0;
         cyc(45);
         freq_ok_in <= 1'b1;
         flag = 1'b0;
         for (n = 0; n < 2200 && on_battery_out; n++) begin
            cyc(1);
            flag |= !main_enable_out;
         end
         tmo(n, 2200);
         chk1(flag, 1'b0);
         d[i] = n;
      end
      chk1(d[0] != d[1], 1'b1);
   endtask : t_return
   // charge request, ramp, timeout and blocked restart
   task t_charge;
      want_charge <= 1'b1;
      for (n = 0; n < 10 && !charger_on_out; n++) cyc(1);
      tmo(n, 10);
      flag = 1'b0;
      for (n = 0; n < 120 && charger_on_out; n++) begin
         cyc(1);
         flag |= (charge_ramp_out == 5'h10);
      end
      chk1(flag, 1'b1);
      chk1(n >= 95 && n < 120, 1'b1);
      cyc(5);
      chk1(charger_on_out, 1'b0);
      rd(bbs_pkg::A_STATUS);
      chk1(st[bbs_pkg::ST_CHG_FAIL], 1'b1);
      want_charge <= 1'b0;
      wr(bbs_pkg::A_CLEAR, 16'h0020);
   endtask : t_charge
   // health test: load qualification, every shelf blocker, worn-out report
   task t_health;
      good = '{installed: 3'h7, comm_ok: 3'h7, failed: 3'h0, testing: 3'h0,
               charging: 3'h0, on_ac: 3'h7};
      shelf_in     <= good;
      load_high_in <= 1'b1;
      want_test    <= 1'b1;
      cyc(14);
      chk1(test_grant_out, 1'b0);
      for (n = 0; n < 20 && !test_grant_out; n++) cyc(1);
      tmo(n, 20);
      for (i = 0; i < 6; i++) begin
         s = good;
         case (i)
            0: s.installed[1] = 1'b0;
            1: s.comm_ok[2] = 1'b0;
            2: s.failed[0] = 1'b1;
            3: s.testing[1] = 1'b1;
            4: s.charging[2] = 1'b1;
            default: s.on_ac[0] = 1'b0;
         endcase
         shelf_in <= s;
         cyc(1);
         chk1(test_grant_out, 1'b0);
         shelf_in <= good;
         cyc(1);
         chk1(test_grant_out, 1'b1);
      end
      load_high_in <= 1'b0;
      want_test    <= 1'b0;
      cyc(1);
      chk1(test_grant_out, 1'b0);
      rd(bbs_pkg::A_STATUS);
      chk1(st[bbs_pkg::ST_WORN], 1'b1);
   endtask : t_health
   // clock
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // reset and scenario sequence
   initial begin
      {rst_in, ce_in, ac_ok_in, freq_ok_in} = 4'hF;
      {main_ov_in, main_oc_in, batt_ov_in, batt_uv_in, load_high_in} = 5'h00;
      {wr_in, rd_in, i2c_done_in, want_charge, want_test} = 5'h00;
      {addr_in, wdata_in, i2c_rdata_in, shelf_in} = '0;
      miscompares = 0;
      check_count = 0;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      t_regs;
      t_hold;
      t_faults;
      t_backup;
      t_return;
      t_charge;
      t_health;
      results;
   end
endmodule : testbench
`default_nettype wire

// ---- verilog/bbs_pkg.sv ----
// shared constants and carrier types for the battery backup supervisor
package bbs_pkg;
   // clock and tick
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned TICK_MS         = 1;
   localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   // backup intervals, in seconds, hours, minutes or milliseconds as each name gives
   localparam int unsigned WARN_S          = 45;
   localparam int unsigned SHUTDOWN_S      = 90;
   localparam int unsigned CHARGE_LIMIT_H  = 5;
   localparam int unsigned LOAD_QUAL_MIN   = 1;
   localparam int unsigned OC_DELAY_S      = 2;
   localparam int unsigned OV_LATCH_MS     = 1;
   // same intervals as tick counts, except OV_LATCH_MS; then soft start and ramp ticks and the module count
   localparam int unsigned WARN_TICKS      = WARN_S * 1000 / TICK_MS;
   localparam int unsigned SHUTDOWN_TICKS  = SHUTDOWN_S * 1000 / TICK_MS;
   localparam int unsigned CHARGE_TICKS    = CHARGE_LIMIT_H * 3600 * 1000 / TICK_MS;
   localparam int unsigned LOAD_TICKS      = LOAD_QUAL_MIN * 60 * 1000 / TICK_MS;
   localparam int unsigned OC_TICKS        = OC_DELAY_S * 1000 / TICK_MS;
   localparam int unsigned SOFT_TICKS      = 16;
   localparam int unsigned RAMP_TICKS      = 16;
   localparam int unsigned MODULES         = 3;
   // status word bit positions and width
   localparam int unsigned ST_AC_UV        = 0;
   localparam int unsigned ST_MAIN_OV      = 1;
   localparam int unsigned ST_MAIN_OC      = 2;
   localparam int unsigned ST_BATT_OV      = 3;
   localparam int unsigned ST_BATT_UV      = 4;
   localparam int unsigned ST_CHG_FAIL     = 5;
   localparam int unsigned ST_WORN         = 6;
   localparam int unsigned ST_BATT_FAIL    = 7;
   localparam int unsigned ST_WARN         = 8;
   localparam int unsigned ST_ON_DC        = 9;
   localparam int unsigned ST_CHARGING     = 10;
   localparam int unsigned ST_TEST_GRANT   = 11;
   localparam int unsigned ST_W            = 16;
   // register addresses and status reset value
   localparam logic [3:0]  A_STATUS        = 4'h0;
   localparam logic [3:0]  A_CLEAR         = 4'h1;
   localparam logic [3:0]  A_I2C_CMD       = 4'h2;
   localparam logic [3:0]  A_I2C_DATA      = 4'h3;
   localparam logic [15:0] RESET_VALUE     = 16'h0000;

   // eight discrete lines from the battery unit
   typedef struct packed {
      logic charge_request;
      logic health_test_request;
      logic battery_worn_out;
      logic battery_failure;
      logic battery_protection;
      logic battery_sleep;
      logic stop_discharge;
      logic present;
   } bbs_lines_t;

   // shelf-wide qualifiers for a health test
   typedef struct packed {
      logic [MODULES-1:0] installed;
      logic [MODULES-1:0] comm_ok;
      logic [MODULES-1:0] failed;
      logic [MODULES-1:0] testing;
      logic [MODULES-1:0] charging;
      logic [MODULES-1:0] on_ac;
   } bbs_shelf_t;

   typedef enum logic [2:0] {
      BBS_AC   = 3'b000,
      BBS_SOFT = 3'b001,
      BBS_DC   = 3'b010,
      BBS_XFER = 3'b011,
      BBS_OFF  = 3'b100
   } bbs_state_t;
endpackage : bbs_pkg

// ---- verilog/bbs_supervisor.sv ----
// battery backup supervisor sequencer with fault latches and status port
`timescale 1ns/100ps
`default_nettype none

module bbs_supervisor #(
   parameter int unsigned TICK_CYCLES    = bbs_pkg::TICK_CYCLES,
   parameter int unsigned WARN_TICKS     = bbs_pkg::WARN_TICKS,
   parameter int unsigned SHUTDOWN_TICKS = bbs_pkg::SHUTDOWN_TICKS,
   parameter int unsigned CHARGE_TICKS   = bbs_pkg::CHARGE_TICKS,
   parameter int unsigned LOAD_TICKS     = bbs_pkg::LOAD_TICKS,
   parameter int unsigned OC_TICKS       = bbs_pkg::OC_TICKS
) (
   input  wire logic                 clk_in,            // 100 MHz clock
   input  wire logic                 rst_in,            // async reset, high
   input  wire logic                 ce_in,             // clock enable
   input  wire logic                 ac_ok_in,          // AC above on threshold
   input  wire logic                 freq_ok_in,        // line frequency valid
   input  wire logic                 main_ov_in,        // fast overvoltage trip
   input  wire logic                 main_oc_in,        // slow overcurrent over limit
   input  wire logic                 batt_ov_in,        // battery overvoltage
   input  wire logic                 batt_uv_in,        // battery undervoltage
   input  wire logic                 load_high_in,      // load above 500 W
   input  wire bbs_pkg::bbs_lines_t  lines_in,          // battery unit lines
   input  wire bbs_pkg::bbs_shelf_t  shelf_in,          // other modules state
   input  wire logic [3:0]           addr_in,           // register address
   input  wire logic [15:0]          wdata_in,          // register write data
   input  wire logic                 wr_in,             // write strobe
   input  wire logic                 rd_in,             // read strobe
   output logic [15:0]               rdata_out,         // read data, next cycle
   input  wire logic                 i2c_done_in,       // I2C engine finished
   input  wire logic [7:0]           i2c_rdata_in,      // I2C byte read back
   output logic                      i2c_start_out,     // I2C transfer pulse
   output logic [15:0]               i2c_cmd_out,       // I2C register and data
   output logic                      on_battery_out,    // DC operation selected
   output logic                      soft_start_out,    // bulk soft start active
   output logic                      main_enable_out,   // main output on
   output logic                      backup_power_warning_out, // warning
   output logic                      charger_on_out,    // charger running
   output logic [4:0]                charge_ramp_out,   // charger current ramp
   output logic                      test_grant_out     // health test granted
);
   localparam int unsigned SW = 32;

   // prescaled tick
   logic [SW-1:0] pre_reg, pre_next;
   logic          tick;
   always_comb begin
      tick     = (pre_reg == SW'(TICK_CYCLES - 1));
      pre_next = tick ? '0 : pre_reg + 1'b1;
   end

   // random delay source: 16-bit LFSR
   logic [15:0] lfsr_reg, lfsr_next;
   always_comb begin
      lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
   end

   // backup sequencer
   bbs_pkg::bbs_state_t st_reg, st_next;
   logic [SW-1:0] dc_reg, dc_next;
   logic [SW-1:0] dly_reg, dly_next;
   logic          warn_reg, warn_next;
   logic          ac_valid;
   logic          latched;
   logic [15:0]   status_reg, status_next;
   always_comb begin
      ac_valid  = ac_ok_in && freq_ok_in;
      st_next   = st_reg;
      dc_next   = dc_reg;
      dly_next  = dly_reg;
      warn_next = warn_reg;
      unique case (st_reg)
         bbs_pkg::BBS_AC: begin
            dc_next   = '0;
            warn_next = 1'b0;
            if (!ac_valid && !latched) begin
               st_next  = bbs_pkg::BBS_SOFT;
               dly_next = '0;
            end
         end
         bbs_pkg::BBS_SOFT: begin
            if (tick) begin
               dly_next = dly_reg + 1'b1;
               dc_next  = dc_reg + 1'b1;
            end
            if (dly_reg == SW'(bbs_pkg::SOFT_TICKS)) begin
               st_next = bbs_pkg::BBS_DC;
            end
         end
         bbs_pkg::BBS_DC, bbs_pkg::BBS_XFER: begin
            if (tick) begin
               dc_next = dc_reg + 1'b1;
            end
            if (dc_reg >= SW'(WARN_TICKS)) begin
               warn_next = 1'b1;
            end
            if (dc_reg >= SW'(SHUTDOWN_TICKS)) begin
               st_next = bbs_pkg::BBS_OFF;
            end else if (st_reg == bbs_pkg::BBS_DC && ac_valid) begin
               st_next  = bbs_pkg::BBS_XFER;
               dly_next = SW'(lfsr_reg[9:0]);
            end else if (st_reg == bbs_pkg::BBS_XFER) begin
               if (!ac_valid) begin
                  st_next = bbs_pkg::BBS_DC;
               end else if (dly_reg == '0) begin
                  st_next = bbs_pkg::BBS_AC;
               end else if (tick) begin
                  dly_next = dly_reg - 1'b1;
               end
            end
         end
         bbs_pkg::BBS_OFF: begin
            warn_next = 1'b0;
            if (ac_valid && !latched) begin
               st_next = bbs_pkg::BBS_AC;
            end
         end
         default: begin
            st_next = bbs_pkg::BBS_AC;
         end
      endcase
      if (latched && st_reg != bbs_pkg::BBS_OFF) begin
         st_next = bbs_pkg::BBS_OFF;
      end
   end

   // charger with ramp and timeout
   logic          chg_reg, chg_next;
   logic [4:0]    ramp_reg, ramp_next;
   logic [SW-1:0] chg_t_reg, chg_t_next;
   always_comb begin
      chg_next   = chg_reg;
      ramp_next  = ramp_reg;
      chg_t_next = chg_t_reg;
      if (chg_reg) begin
         if (tick) begin
            chg_t_next = chg_t_reg + 1'b1;
            if (ramp_reg != 5'(bbs_pkg::RAMP_TICKS)) begin
               ramp_next = ramp_reg + 1'b1;
            end
         end
         if (!lines_in.charge_request || st_reg != bbs_pkg::BBS_AC
             || chg_t_reg >= SW'(CHARGE_TICKS)) begin
            chg_next  = 1'b0;
            ramp_next = '0;
         end
      end else if (lines_in.charge_request && st_reg == bbs_pkg::BBS_AC
                   && !status_reg[bbs_pkg::ST_CHG_FAIL]) begin
         chg_next   = 1'b1;
         chg_t_next = '0;
      end
   end

   // fault timing and load qualification
   logic [SW-1:0] oc_reg, oc_next;
   logic [SW-1:0] load_reg, load_next;
   logic          test_ok;
   always_comb begin
      oc_next   = main_oc_in ? (tick ? oc_reg + 1'b1 : oc_reg) : '0;
      load_next = load_high_in ? (tick && load_reg != SW'(LOAD_TICKS)
                                  ? load_reg + 1'b1 : load_reg) : '0;
      test_ok   = lines_in.health_test_request
               && (&shelf_in.installed) && (&shelf_in.comm_ok)
               && !(|shelf_in.failed) && !lines_in.battery_failure
               && !(|shelf_in.testing) && !(|shelf_in.charging)
               && (&shelf_in.on_ac) && !chg_reg && !latched
               && st_reg == bbs_pkg::BBS_AC
               && load_reg == SW'(LOAD_TICKS);
   end

   // status flags, sticky until cleared; set wins over clear
   logic [15:0] set_bits;
   logic [15:0] clr_bits;
   always_comb begin
      set_bits = '0;
      set_bits[bbs_pkg::ST_AC_UV]     = !ac_valid;
      set_bits[bbs_pkg::ST_MAIN_OV]   = main_ov_in;
      set_bits[bbs_pkg::ST_MAIN_OC]   = oc_reg >= SW'(OC_TICKS);
      set_bits[bbs_pkg::ST_BATT_OV]   = batt_ov_in;
      set_bits[bbs_pkg::ST_BATT_UV]   = batt_uv_in;
      set_bits[bbs_pkg::ST_CHG_FAIL]  = chg_reg && chg_t_reg >= SW'(CHARGE_TICKS);
      set_bits[bbs_pkg::ST_WORN]      = lines_in.battery_worn_out;
      set_bits[bbs_pkg::ST_BATT_FAIL] = lines_in.battery_failure;
      clr_bits = (wr_in && addr_in == bbs_pkg::A_CLEAR) ? wdata_in : '0;
      status_next = (status_reg & ~clr_bits) | set_bits;
      latched = status_reg[bbs_pkg::ST_MAIN_OV] || status_reg[bbs_pkg::ST_MAIN_OC];
   end

   // register port and I2C pass-through
   logic [15:0] rdata_reg, rdata_next;
   logic [15:0] cmd_reg, cmd_next;
   logic        start_reg, start_next;
   logic [7:0]  i2c_reg, i2c_next;
   logic [15:0] live;
   always_comb begin
      live = status_reg;
      live[bbs_pkg::ST_WARN]       = warn_reg;
      live[bbs_pkg::ST_ON_DC]      = st_reg != bbs_pkg::BBS_AC;
      live[bbs_pkg::ST_CHARGING]   = chg_reg;
      live[bbs_pkg::ST_TEST_GRANT] = test_ok;
      cmd_next   = cmd_reg;
      start_next = 1'b0;
      i2c_next   = i2c_done_in ? i2c_rdata_in : i2c_reg;
      if (wr_in && addr_in == bbs_pkg::A_I2C_CMD) begin
         cmd_next   = wdata_in;
         start_next = 1'b1;
      end
      rdata_next = '0;
      if (rd_in) begin
         unique case (addr_in)
            bbs_pkg::A_STATUS:   rdata_next = live;
            bbs_pkg::A_I2C_CMD:  rdata_next = cmd_reg;
            bbs_pkg::A_I2C_DATA: rdata_next = {8'h00, i2c_reg};
            default:             rdata_next = '0;
         endcase
      end
   end

   // tick prescaler register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pre_reg <= '0;
      end else if (ce_in) begin
         pre_reg <= pre_next;
      end
   end

   // random source register, seed arbitrary but nonzero
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         lfsr_reg <= 16'hACE1;
      end else if (ce_in) begin
         lfsr_reg <= lfsr_next;
      end
   end

   // sequencer registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_reg   <= bbs_pkg::BBS_AC;
         dc_reg   <= '0;
         dly_reg  <= '0;
         warn_reg <= 1'b0;
      end else if (ce_in) begin
         st_reg   <= st_next;
         dc_reg   <= dc_next;
         dly_reg  <= dly_next;
         warn_reg <= warn_next;
      end
   end

   // charger registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         chg_reg   <= 1'b0;
         ramp_reg  <= '0;
         chg_t_reg <= '0;
      end else if (ce_in) begin
         chg_reg   <= chg_next;
         ramp_reg  <= ramp_next;
         chg_t_reg <= chg_t_next;
      end
   end

   // fault and load counters
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         oc_reg   <= '0;
         load_reg <= '0;
      end else if (ce_in) begin
         oc_reg   <= oc_next;
         load_reg <= load_next;
      end
   end

   // sticky status flags
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         status_reg <= bbs_pkg::RESET_VALUE;
      end else if (ce_in) begin
         status_reg <= status_next;
      end
   end

   // register port and link registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_reg <= '0;
         cmd_reg   <= '0;
         start_reg <= 1'b0;
         i2c_reg   <= '0;
      end else if (ce_in) begin
         rdata_reg <= rdata_next;
         cmd_reg   <= cmd_next;
         start_reg <= start_next;
         i2c_reg   <= i2c_next;
      end
   end

   // outputs
   assign rdata_out                = rdata_reg;
   assign i2c_start_out            = start_reg;
   assign i2c_cmd_out              = cmd_reg;
   assign on_battery_out           = st_reg == bbs_pkg::BBS_SOFT || st_reg == bbs_pkg::BBS_DC
                                     || st_reg == bbs_pkg::BBS_XFER;
   assign soft_start_out           = st_reg == bbs_pkg::BBS_SOFT;
   assign main_enable_out          = st_reg != bbs_pkg::BBS_OFF;
   assign backup_power_warning_out = warn_reg;
   assign charger_on_out           = chg_reg;
   assign charge_ramp_out          = ramp_reg;
   assign test_grant_out           = test_ok;
endmodule : bbs_supervisor

`default_nettype wire
